/* File: bench/cap_model.sv */
`include "video_cfg.svh"
module cap_model (
  input wire logic pclk,
  input wire logic edge_f,
  input wire logic [`PIX_W-1:0] d,
  input wire logic hs,
  input wire logic vs,
  input wire logic pol_h,
  input wire logic pol_v
);
  timeunit 1ns;
  timeprecision 100ps;
  int frames = 0, words = 0, lines = 0, hsn = 0, hcnt = 0, ln = 0, wd = 0, wc = 0;
  logic [`PIX_W-1:0] w [128];
  logic hq = 1'b0, vq = 1'b0, ha, va;
  // ****
  // Capture on the edge opposite launch
  // ****
  always @(pclk) begin
    if (pclk === edge_f) begin
      ha = (hs === pol_h);
      va = (vs === pol_v);
      if (va && !vq) begin
        ln = 0;
        wd = 0;
        wc = 0;
      end
      if (ha && !hq) hcnt++;
      if (ha && va) begin
        if (ln < 8 && wd < 16) w[ln * 16 + wd] = d;
        wd++;
        wc++;
      end
      // Last line may end with the vsync fall
      if (!ha && hq && (va || vq)) begin
        ln++;
        wd = 0;
      end
      if (!va && vq) begin
        frames++;
        words = wc;
        lines = ln;
        hsn = hcnt;
        hcnt = 0;
      end
      hq = ha;
      vq = va;
    end
  end
endmodule : cap_model

/* File: bench/parallel_video_readout_timing_bench.sv */
`include "video_cfg.svh"
module parallel_video_readout_timing_bench
  import video_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic video_timing_clock = 1'b0;
  logic rst_b = 1'b0, stream_on = 1'b0, par_select = 1'b1, edge_falling = 1'b0, geom_load = 1'b0;
  logic hsync_en = 1'b1, hsync_pol_high = 1'b1, hsync_all_lines = 1'b0;
  logic vsync_en = 1'b1, vsync_pol_high = 1'b1;
  logic [`ADDR_W-1:0] x_addr_start = '0, x_addr_end = '0, y_addr_start = '0, y_addr_end = '0;
  logic [`ADDR_W-1:0] x_output_size = '0, y_output_size = '0;
  logic [`INC_W-1:0] x_odd_inc = 4'h1, x_even_inc = 4'h1, y_odd_inc = 4'h1, y_even_inc = 4'h1;
  // Far below the host minimums, to keep runs short
  logic [`CNT_W-1:0] line_length = 17'h00028, frame_length = 17'h0001e;
  logic geom_busy, frame_done, embed_sel, par_data_oe, par_hsync, par_hsync_oe;
  logic par_vsync, par_vsync_oe, par_pclk, par_pclk_oe;
  logic [`ADDR_W-1:0] array_col, array_row;
  logic [`PIX_W-1:0] par_data, raw_bayer_12bit, embed_data;
  wire [`PIX_W-1:0] pin_d = par_data_oe ? par_data : 'z;
  wire pin_h = par_hsync_oe ? par_hsync : 1'bz;
  wire pin_v = par_vsync_oe ? par_vsync : 1'bz;
  wire pin_c = par_pclk_oe ? par_pclk : 1'bz;
  int fail_count = 0, total_checks = 0, cycles = 0, emb = 0, emb_f = 0, fr_q = 0;
  int done_n = 0;
  // ****
  // Array stand-in: each word encodes its address
  // ****
  assign raw_bayer_12bit = {array_row[5:0], array_col[5:0]};
  assign embed_data = ~raw_bayer_12bit;
  always #10 clk_sys = ~clk_sys;
  initial begin
    #1.7;
    forever #3 video_timing_clock = ~video_timing_clock;
  end
  video_par_out i_video_par_out (.*);
  cap_model i_cap_model (.pclk(pin_c), .edge_f(edge_falling), .d(pin_d), .hs(pin_h),
    .vs(pin_v), .pol_h(hsync_pol_high), .pol_v(vsync_pol_high));
  always @(posedge video_timing_clock) begin
    // Word seen at the boundary edge starts the new count, so none is lost
    if (i_cap_model.frames != fr_q) begin
      emb_f <= emb;
      emb <= (embed_sel === 1'b1) ? 1 : 0;
      fr_q <= i_cap_model.frames;
    end else if (embed_sel === 1'b1) begin
      emb <= emb + 1;
    end
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (frame_done === 1'b1) begin
      done_n <= done_n + 1;
    end
    if (cycles == 20000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic chk_cnt(string what, int exp_v, int seen);
    total_checks++;
    if (exp_v != seen) begin
      fail_count++;
      $display("unexpected %s expected %0d seen %0d", what, exp_v, seen);
    end
  endtask : chk_cnt
  task automatic chk_pix(int idx, logic [`PIX_W-1:0] exp_v, logic [`PIX_W-1:0] seen);
    total_checks++;
    if (exp_v !== seen) begin
      fail_count++;
      $display("unexpected pixel %0d expected %h seen %h", idx, exp_v, seen);
    end
  endtask : chk_pix
  function automatic int nxt(int a, int odd_v, int even_v);
    return a[0] ? a + odd_v : a + even_v;
  endfunction : nxt
  task automatic do_reset();
    rst_b <= 1'b0;
    stream_on <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask : do_reset
  task automatic quiet();
    int f;
    repeat (10) @(posedge clk_sys);
    f = i_cap_model.frames;
    repeat (1000) @(posedge clk_sys);
    chk_cnt("frames while quiet", f, i_cap_model.frames);
  endtask : quiet
  // Geometry loads with streaming stopped, then two frames pass
  task automatic run(int xs, int xe, int ys, int ye, int xo, int yo, int xoi, int xei, int yoi);
    int n;
    int f;
    int r;
    int c;
    int d;
    logic [`PIX_W-1:0] e;
    stream_on <= 1'b0;
    repeat (20) @(posedge clk_sys);
    x_addr_start <= 11'(xs);
    x_addr_end <= 11'(xe);
    y_addr_start <= 11'(ys);
    y_addr_end <= 11'(ye);
    x_output_size <= 11'(xo);
    y_output_size <= 11'(yo);
    x_odd_inc <= 4'(xoi);
    x_even_inc <= 4'(xei);
    y_odd_inc <= 4'(yoi);
    geom_load <= 1'b1;
    @(posedge clk_sys);
    geom_load <= 1'b0;
    repeat (3) @(posedge clk_sys);
    for (n = 0; n < 50 && geom_busy !== 1'b0; n++) @(posedge clk_sys);
    stream_on <= 1'b1;
    f = i_cap_model.frames;
    d = done_n;
    for (n = 0; n < 3000 && i_cap_model.frames < f + 2; n++) @(posedge clk_sys);
    // Frame done needs two control-clock stages after the last visible line
    repeat (4) @(posedge clk_sys);
    chk_cnt("frames", f + 2, i_cap_model.frames);
    chk_cnt("frame done pulses", 2, done_n - d);
    chk_cnt("words", xo * yo, i_cap_model.words);
    chk_cnt("lines", yo, i_cap_model.lines);
    chk_cnt("hsync pulses", hsync_all_lines ? int'(frame_length) : yo, i_cap_model.hsn);
    chk_cnt("embedded words", 12 * xo, emb_f);
    r = ys;
    for (int j = 0; j < yo; j++) begin
      c = xs;
      for (int k = 0; k < xo; k++) begin
        e = (c > xe || r > ye) ? 12'h000 : {r[5:0], c[5:0]};
        chk_pix(j * 16 + k, e, i_cap_model.w[j * 16 + k]);
        c = nxt(c, xoi, xei);
      end
      r = nxt(r, yoi, 1);
    end
  endtask : run
  initial begin
    do_reset();
    run(0, 31, 0, 15, 16, 8, 1, 1, 1);
    hsync_all_lines <= 1'b1;
    run(2, 33, 0, 15, 8, 8, 1, 3, 3);
    run(0, 7, 0, 3, 12, 6, 1, 1, 1);
    hsync_en <= 1'b0;
    vsync_en <= 1'b0;
    quiet();
    hsync_en <= 1'b1;
    vsync_en <= 1'b1;
    par_select <= 1'b0;
    quiet();
    par_select <= 1'b1;
    hsync_pol_high <= 1'b0;
    vsync_pol_high <= 1'b0;
    hsync_all_lines <= 1'b0;
    edge_falling <= 1'b1;
    do_reset();
    run(0, 31, 0, 15, 16, 8, 1, 1, 1);
    final_report();
  end
endmodule : parallel_video_readout_timing_bench

/* File: bench/video_par_out_checker.sv */
module video_par_out_checker (
  input logic clk_sys,
  input logic rst_b,
  input logic video_timing_clock,
  input logic par_select,
  input logic hsync_en,
  input logic hsync_pol_high,
  input logic hsync_all_lines,
  input logic vsync_en,
  input logic vsync_pol_high,
  input logic geom_load,
  input logic geom_busy,
  input logic frame_done,
  input logic embed_sel,
  input logic par_data_oe,
  input logic par_hsync,
  input logic par_hsync_oe,
  input logic par_vsync,
  input logic par_vsync_oe,
  input logic par_pclk_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // Five-cycle waits cover the two sync stages
  // ****
  sequence load_s;
    geom_load && !geom_busy;
  endsequence
  sequence ack_s;
    geom_busy ##[1:40] !geom_busy;
  endsequence
  geom_xfer_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    load_s |=> ack_s) else $error("geometry handshake stuck");
  done_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    frame_done |=> !frame_done) else $error("frame done too long");
  oe_off_a: assert property (@(posedge video_timing_clock) disable iff (!rst_b)
    !par_select [*5] |-> !(par_data_oe || par_pclk_oe || par_hsync_oe || par_vsync_oe))
    else $error("driven when off");
  oe_on_a: assert property (@(posedge video_timing_clock) disable iff (!rst_b)
    par_select [*5] |-> par_data_oe && par_pclk_oe && par_hsync_oe && par_vsync_oe)
    else $error("not driven");
  hs_idle_a: assert property (@(posedge video_timing_clock) disable iff (!rst_b)
    !hsync_en [*5] |-> par_hsync != hsync_pol_high) else $error("hsync while off");
  vs_idle_a: assert property (@(posedge video_timing_clock) disable iff (!rst_b)
    !vsync_en [*5] |-> par_vsync != vsync_pol_high) else $error("vsync while off");
  emb_hs_a: assert property (@(posedge video_timing_clock) disable iff (!rst_b)
    embed_sel && $past(embed_sel) && !hsync_all_lines |-> par_hsync != hsync_pol_high)
    else $error("hsync on embedded line");
  emb_vs_a: assert property (@(posedge video_timing_clock) disable iff (!rst_b)
    embed_sel && $past(embed_sel) |-> par_vsync != vsync_pol_high)
    else $error("vsync on embedded line");
endmodule : video_par_out_checker

bind video_par_out video_par_out_checker i_video_par_out_checker (.*);

/* File: common/addr_step_if.sv */
interface addr_step_if #(
  parameter int W = 11,
  parameter int IW = 4
);
  logic [W-1:0] addr;
  logic [IW-1:0] odd_inc;
  logic [IW-1:0] even_inc;
  logic [W-1:0] next_addr;

  modport caller (output addr, output odd_inc, output even_inc, input next_addr);
  modport stepper (input addr, input odd_inc, input even_inc, output next_addr);
endinterface : addr_step_if

/* File: common/video_cfg.svh */
`ifndef VIDEO_CFG_SVH
`define VIDEO_CFG_SVH

// ****************************************
// Widths
// ****************************************
`define PIX_W 12
`define ADDR_W 11
`define INC_W 4
`define CNT_W 17

// ****************************************
// Array and frame structure
// ****************************************
`define ARRAY_COLS 1304
`define ARRAY_ROWS 980
`define LEAD_LINES 2
`define TRAIL_LINES 10
`define PCLK_MAX_MHZ 66

// ****************************************
// Reset values of the geometry
// ****************************************
`define RST_X_START 11'h000
`define RST_X_END 11'h517
`define RST_Y_START 11'h000
`define RST_Y_END 11'h3d3
`define RST_X_OUT 11'h518
`define RST_Y_OUT 11'h3d4
`define RST_INC 4'h1
`define RST_LINE_LEN 17'h0059e
`define RST_FRAME_LEN 17'h003ff

`endif

/* File: common/video_pkg.sv */
package video_pkg;
  `include "video_cfg.svh"

  typedef struct packed {
    logic [`ADDR_W-1:0] x_start;
    logic [`ADDR_W-1:0] x_end;
    logic [`ADDR_W-1:0] y_start;
    logic [`ADDR_W-1:0] y_end;
    logic [`ADDR_W-1:0] x_out;
    logic [`ADDR_W-1:0] y_out;
    logic [`INC_W-1:0] x_odd_inc;
    logic [`INC_W-1:0] x_even_inc;
    logic [`INC_W-1:0] y_odd_inc;
    logic [`INC_W-1:0] y_even_inc;
    logic [`CNT_W-1:0] line_len;
    logic [`CNT_W-1:0] frame_len;
  } geom_t;

  typedef enum logic [1:0] {
    REGION_LEAD,
    REGION_VISIBLE,
    REGION_TRAIL,
    REGION_BLANK
  } region_t;

  typedef struct packed {
    logic [7:0] lvl_s1;
    logic [7:0] lvl_s2;
    logic tog_s1;
    logic tog_s2;
    logic ack_tog;
    logic pend_valid;
    geom_t pend;
    geom_t act;
    logic [`CNT_W-1:0] h_cnt;
    logic [`CNT_W-1:0] v_cnt;
    region_t region;
    logic [`ADDR_W-1:0] x;
    logic [`ADDR_W-1:0] y;
    logic [`PIX_W-1:0] dq;
    logic hs_act;
    logic vs_act;
    logic fdone_tog;
  } pix_state_t;

  typedef struct packed {
    logic req_tog;
    logic ack_s1;
    logic ack_s2;
    geom_t shadow;
    logic fd_s1;
    logic fd_s2;
    logic fd_s3;
  } sys_state_t;
endpackage : video_pkg

/* File: rtl/addr_stepper.sv */
module addr_stepper (
  addr_step_if.stepper s
);
  localparam int AW = $bits(s.addr);
  localparam int IW = $bits(s.odd_inc);
  logic [IW-1:0] step;
  // Parity of the current address picks the increment
  assign step = s.addr[0] ? s.odd_inc : s.even_inc;
  // Carry out of the top bit is dropped on purpose
  assign s.next_addr = s.addr + {{(AW - IW){1'b0}}, step};
endmodule : addr_stepper

/* File: rtl/video_par_out.sv */
`include "video_cfg.svh"
module video_par_out
  import video_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic video_timing_clock,
  input wire logic stream_on,
  input wire logic par_select,
  input wire logic edge_falling,
  input wire logic hsync_en,
  input wire logic hsync_pol_high,
  input wire logic hsync_all_lines,
  input wire logic vsync_en,
  input wire logic vsync_pol_high,
  input wire logic geom_load,
  input wire logic [`ADDR_W-1:0] x_addr_start,
  input wire logic [`ADDR_W-1:0] x_addr_end,
  input wire logic [`ADDR_W-1:0] y_addr_start,
  input wire logic [`ADDR_W-1:0] y_addr_end,
  input wire logic [`ADDR_W-1:0] x_output_size,
  input wire logic [`ADDR_W-1:0] y_output_size,
  input wire logic [`INC_W-1:0] x_odd_inc,
  input wire logic [`INC_W-1:0] x_even_inc,
  input wire logic [`INC_W-1:0] y_odd_inc,
  input wire logic [`INC_W-1:0] y_even_inc,
  input wire logic [`CNT_W-1:0] line_length,
  input wire logic [`CNT_W-1:0] frame_length,
  output logic geom_busy,
  output logic frame_done,
  output logic [`ADDR_W-1:0] array_col,
  output logic [`ADDR_W-1:0] array_row,
  input wire logic [`PIX_W-1:0] raw_bayer_12bit,
  input wire logic [`PIX_W-1:0] embed_data,
  output logic embed_sel,
  output logic [`PIX_W-1:0] par_data,
  output logic par_data_oe,
  output logic par_hsync,
  output logic par_hsync_oe,
  output logic par_vsync,
  output logic par_vsync_oe,
  output logic par_pclk,
  output logic par_pclk_oe
);

  // ****************************************
  // Constants
  // ****************************************
  localparam logic [`CNT_W-1:0] LEAD_N = `CNT_W'(`LEAD_LINES);
  localparam logic [`CNT_W-1:0] TRAIL_N = `CNT_W'(`TRAIL_LINES);
  localparam geom_t GEOM_RST = '{
    x_start: `RST_X_START,
    x_end: `RST_X_END,
    y_start: `RST_Y_START,
    y_end: `RST_Y_END,
    x_out: `RST_X_OUT,
    y_out: `RST_Y_OUT,
    x_odd_inc: `RST_INC,
    x_even_inc: `RST_INC,
    y_odd_inc: `RST_INC,
    y_even_inc: `RST_INC,
    line_len: `RST_LINE_LEN,
    frame_len: `RST_FRAME_LEN
  };

  // Bit positions in the synchronised level vector
  localparam int L_STREAM = 0;
  localparam int L_SELECT = 1;
  localparam int L_FALL = 2;
  localparam int L_HS_EN = 3;
  localparam int L_HS_POL = 4;
  localparam int L_HS_ALL = 5;
  localparam int L_VS_EN = 6;
  localparam int L_VS_POL = 7;

  // ****************************************
  // System clock domain
  // ****************************************
  sys_state_t sq;
  sys_state_t sn;
  pix_state_t pq;
  pix_state_t pn;

  always_comb begin
    sn = sq;
    sn.ack_s1 = pq.ack_tog;
    sn.ack_s2 = sq.ack_s1;
    sn.fd_s1 = pq.fdone_tog;
    sn.fd_s2 = sq.fd_s1;
    sn.fd_s3 = sq.fd_s2;
    // Shadow must stay still until the pixel side has taken it
    if (geom_load && (sq.req_tog == sq.ack_s2)) begin
      sn.shadow.x_start = x_addr_start;
      sn.shadow.x_end = x_addr_end;
      sn.shadow.y_start = y_addr_start;
      sn.shadow.y_end = y_addr_end;
      sn.shadow.x_out = x_output_size;
      sn.shadow.y_out = y_output_size;
      sn.shadow.x_odd_inc = x_odd_inc;
      sn.shadow.x_even_inc = x_even_inc;
      sn.shadow.y_odd_inc = y_odd_inc;
      sn.shadow.y_even_inc = y_even_inc;
      sn.shadow.line_len = line_length;
      sn.shadow.frame_len = frame_length;
      sn.req_tog = ~sq.req_tog;
    end
  end

  // Control side keeps running from the reference clock while idle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sq <= '{req_tog: 1'b0, ack_s1: 1'b0, ack_s2: 1'b0, shadow: GEOM_RST,
              fd_s1: 1'b0, fd_s2: 1'b0, fd_s3: 1'b0};
    end else begin
      sq <= sn;
    end
  end

  assign geom_busy = sq.req_tog ^ sq.ack_s2;
  assign frame_done = sq.fd_s2 ^ sq.fd_s3;

  // ****************************************
  // Address steppers
  // ****************************************
  addr_step_if #(.W(`ADDR_W), .IW(`INC_W)) col_if ();
  addr_step_if #(.W(`ADDR_W), .IW(`INC_W)) row_if ();

  assign col_if.addr = pq.x;
  assign col_if.odd_inc = pq.act.x_odd_inc;
  assign col_if.even_inc = pq.act.x_even_inc;
  assign row_if.addr = pq.y;
  assign row_if.odd_inc = pq.act.y_odd_inc;
  assign row_if.even_inc = pq.act.y_even_inc;

  addr_stepper u_col_step (
    .s(col_if)
  );

  addr_stepper u_row_step (
    .s(row_if)
  );

  // ****************************************
  // Video timing clock domain
  // ****************************************
  function automatic region_t region_of(input logic [`CNT_W-1:0] v, input geom_t g);
    logic [`CNT_W-1:0] vis_end;
    vis_end = LEAD_N + `CNT_W'(g.y_out);
    if (v < LEAD_N) begin
      return REGION_LEAD;
    end else if (v < vis_end) begin
      return REGION_VISIBLE;
    end else if (v < vis_end + TRAIL_N) begin
      return REGION_TRAIL;
    end else begin
      return REGION_BLANK;
    end
  endfunction : region_of

  logic [7:0] lvl;
  logic in_word;
  logic in_window;
  logic line_end;
  logic frame_end;

  assign lvl = {vsync_pol_high, vsync_en, hsync_all_lines, hsync_pol_high, hsync_en,
                edge_falling, par_select, stream_on};

  always_comb begin
    pn = pq;
    pn.lvl_s1 = lvl;
    pn.lvl_s2 = pq.lvl_s1;
    pn.tog_s1 = sq.req_tog;
    pn.tog_s2 = pq.tog_s1;
    // Output width counts from the left edge; beyond it nothing is sent
    in_word = (pq.h_cnt < `CNT_W'(pq.act.x_out));
    // Outside the programmed window the word is padding
    in_window = (pq.x <= pq.act.x_end) && (pq.y <= pq.act.y_end);
    line_end = (pq.h_cnt == pq.act.line_len - `CNT_W'(1));
    frame_end = line_end && (pq.v_cnt == pq.act.frame_len - `CNT_W'(1));
    pn.hs_act = 1'b0;
    pn.vs_act = 1'b0;
    pn.dq = '0;

    if (!pq.lvl_s2[L_STREAM]) begin
      // Idle: clear counters, take any pending geometry at once
      pn.h_cnt = '0;
      pn.v_cnt = '0;
      pn.x = pq.act.x_start;
      pn.y = pq.act.y_start;
      if (pq.pend_valid) begin
        pn.act = pq.pend;
        pn.pend_valid = 1'b0;
        pn.x = pq.pend.x_start;
        pn.y = pq.pend.y_start;
      end
      pn.region = REGION_LEAD;
    end else begin
      // Word of the current cycle
      if (in_word && (pq.region != REGION_BLANK)) begin
        if (pq.region == REGION_VISIBLE) begin
          pn.dq = in_window ? raw_bayer_12bit : '0;
          pn.x = col_if.next_addr;
        end else begin
          pn.dq = embed_data;
        end
      end
      pn.hs_act = in_word && ((pq.region == REGION_VISIBLE) || pq.lvl_s2[L_HS_ALL]);
      pn.vs_act = (pq.region == REGION_VISIBLE);

      // Line and frame counting
      if (line_end) begin
        pn.h_cnt = '0;
        pn.x = pq.act.x_start;
        if (pq.region == REGION_VISIBLE) begin
          pn.y = row_if.next_addr;
        end
        if (frame_end) begin
          pn.v_cnt = '0;
          pn.y = pq.act.y_start;
          if (pq.pend_valid) begin
            pn.act = pq.pend;
            pn.pend_valid = 1'b0;
            pn.x = pq.pend.x_start;
            pn.y = pq.pend.y_start;
          end
        end else begin
          pn.v_cnt = pq.v_cnt + `CNT_W'(1);
        end
        pn.region = region_of(pn.v_cnt, pn.act);
        if ((pq.region == REGION_VISIBLE) && (pn.region != REGION_VISIBLE)) begin
          pn.fdone_tog = ~pq.fdone_tog;
        end
      end else begin
        pn.h_cnt = pq.h_cnt + `CNT_W'(1);
      end
    end

    // New geometry arrival is applied after the boundary so it is not lost
    if (pq.tog_s2 != pq.ack_tog) begin
      pn.pend = sq.shadow;
      pn.pend_valid = 1'b1;
      pn.ack_tog = pq.tog_s2;
    end
  end

  // Readout and output are clocked by the video timing clock
  always_ff @(posedge video_timing_clock or negedge rst_b) begin
    if (!rst_b) begin
      pq <= '{lvl_s1: 8'h00, lvl_s2: 8'h00, tog_s1: 1'b0, tog_s2: 1'b0, ack_tog: 1'b0,
              pend_valid: 1'b0, pend: GEOM_RST, act: GEOM_RST, h_cnt: '0, v_cnt: '0,
              region: REGION_LEAD, x: `RST_X_START, y: `RST_Y_START, dq: '0,
              hs_act: 1'b0, vs_act: 1'b0, fdone_tog: 1'b0};
    end else begin
      pq <= pn;
    end
  end

  // ****************************************
  // Pins
  // ****************************************
  assign array_col = pq.x;
  assign array_row = pq.y;
  assign embed_sel = pq.lvl_s2[L_STREAM] && (pq.region != REGION_VISIBLE) &&
                     (pq.region != REGION_BLANK) && (pq.h_cnt < `CNT_W'(pq.act.x_out));

  assign par_data = pq.dq;
  // Disabled sync rests at its inactive level
  assign par_hsync = (pq.hs_act && pq.lvl_s2[L_HS_EN]) ~^ pq.lvl_s2[L_HS_POL];
  assign par_vsync = (pq.vs_act && pq.lvl_s2[L_VS_EN]) ~^ pq.lvl_s2[L_VS_POL];
  // Inverting the clock moves the data change to the other edge
  assign par_pclk = video_timing_clock ^ pq.lvl_s2[L_FALL];
  assign par_data_oe = pq.lvl_s2[L_SELECT];
  assign par_hsync_oe = pq.lvl_s2[L_SELECT];
  assign par_vsync_oe = pq.lvl_s2[L_SELECT];
  assign par_pclk_oe = pq.lvl_s2[L_SELECT];

endmodule : video_par_out
